// File: logic/ddn_map.svh
// Purpose: Offsets, field positions and reset values of the deinterlace state block.
// Assumes: Included by its bare name wherever the map is needed.
// Notes: Definitions only.
`ifndef DDN_MAP_SVH
`define DDN_MAP_SVH
// ==========================================================
// Array layout and register bus map
`define DDN_ELEMS 8
`define DDN_ELEM_DW 8
`define DDN_IDX_MUL 2
`define DDN_ADR_STATUS 8'h40
`define DDN_ADR_CONTROL 8'h41
`define DDN_ARRAY_TOP 8'h3F
`define DDN_WORD_RST 32'h0000_0000
`define DDN_CTL_WALK_CLR 0
// ==========================================================
// Dword indices inside one element
`define DDN_DW_TEMPORAL 3'h1
`define DDN_DW_BLEND 3'h3
`define DDN_DW_SHIFT 3'h4
`define DDN_DW_FLAGS 3'h6
`define DDN_DW_WALK 3'h7
// ==========================================================
// Field positions
`define DDN_TD_HI 29:24
`define DDN_TD_LO 21:16
`define DDN_C2 15:13
`define DDN_MOVE_TH 12:8
`define DDN_BLEND_SEL 31
`define DDN_BLEND_LARGE 30:24
`define DDN_BLEND_SMALL 23:16
`define DDN_STMM_MAX 7:0
`define DDN_STMM_MIN 31:24
`define DDN_SHIFT_DOWN 23:22
`define DDN_SHIFT_UP 21:20
`define DDN_OUT_SHIFT 19:16
`define DDN_PROGRESSIVE 6
`define DDN_FIRST_FRAME 5
`define DDN_STREAM_ID 4
`define DDN_TOP_FIRST 3
`define DDN_PARTIAL 2
`define DDN_DI_EN 1
`define DDN_NR_EN 0
`define DDN_COL_WIDTH 31:23
`define DDN_WALK_EN 18
`define DDN_MERGE_PREV 17:16
`define DDN_MERGE_CUR 9:8
// ==========================================================
// Decoding constants
`define DDN_SHIFT_DOWN_BASE 3'h4
`define DDN_SHIFT_UP_BASE 4'h6
`define DDN_SHIFT_RSVD 2'h3
`define DDN_ONE4 4'h1
`define DDN_ONE10 10'h001
`define DDN_STEP_ADJ 2'h1
`define DDN_STEP_ALT 2'h2
`endif

// File: logic/ddn_pkg.sv
// Purpose: Types shared by the deinterlace state block.
// Assumes: Field positions come from ddn_map.svh.
// Notes: Types only.
`default_nettype none
package ddn_pkg;
    // Field-merge decision for one field.
    typedef enum logic [1:0] {
        DDN_MERGE_DEINTERLACE,
        DDN_MERGE_PREVIOUS,
        DDN_MERGE_NEXT,
        DDN_MERGE_UNDEFINED
    } ddn_merge_t;
    // Message as issued by the execution thread.
    typedef struct packed {
        logic [4:0] samplerIndex;
        logic [4:0] movingCount;
        logic [15:0] posX;
        logic [15:0] posY;
    } ddn_msg_t;
    // Decoded element handed to the filter datapath.
    typedef struct packed {
        logic [1:0] lineStep;
        logic prevCleanValid;
        logic streamSel;
        logic topFirst;
        logic partialWriteback;
        logic deinterlacing;
        logic noiseReduction;
        logic readOriginalPrev;
        logic [3:0] divisor;
        logic [2:0] shiftDown;
        logic [3:0] shiftUp;
        logic [3:0] outShift;
        logic [7:0] motionDetectThreshold;
        logic [7:0] motionMax;
        logic [7:0] motionMin;
        logic [5:0] tdHigh;
        logic [5:0] tdLow;
        logic blockMoving;
        logic [9:0] columnWidth;
        logic useWalker;
        logic [15:0] blockX;
        logic [15:0] blockY;
        ddn_merge_t prevMerge;
        ddn_merge_t curMerge;
    } ddn_cfg_t;
    // Faults seen while decoding a message.
    typedef struct packed {
        logic badIndex;
        logic reservedShift;
        logic bothOff;
        logic badMerge;
    } ddn_err_t;
endpackage
`default_nettype wire

// File: logic/ddn_state.sv
// Purpose: Holds the deinterlace/denoise state array and decodes one element per message.
// Assumes: One clock; message inputs synchronous to clk_sys.
// Notes: Software programs the array over classic Wishbone.
//
// Overview of operation
// R1 - Up to eight elements, each eight dwords after the previous one.
// R2 - Software places the array start on a 32-byte boundary.
// R3 - Element index 0..7 selects an element; sampler index is twice it.
// R4 - Software keeps history limit 128..240 and history step 0..15.
// R5 - Software keeps high minus low temporal threshold in 1..16.
// R6 - Divisor bias code 0..7 is used as value 1..8.
// R7 - Block is moving when its moving pixel count exceeds the threshold.
// R8 - Motion_blend_constants bit 31 picks large or small blending constant.
// R9 - Down-shift codes 0,1,2 mean 4,5,6; code 3 is reserved.
// R10 - Up-shift codes 0,1,2 mean 6,7,8; code 3 is reserved.
// R11 - Software sets output shift so max minus min is two to it.
// R12 - Progressive filters adjacent lines, else alternate; deinterlacing then off (the decode passes the enable bit through unchanged).
// R13 - First-frame flag marks the previous cleaned surface invalid.
// R14 - Stream selector picks which stream's estimate and counters update.
// R15 - Field-order flag one means top field first, zero bottom first.
// R16 - Partial writeback only when deinterlacing and partial flag are set.
// R17 - Deinterlacing off passes input through and zeroes motion results.
// R18 - Noise reduction off drops denoised fields and reads original previous.
// R19 - Software never clears both deinterlacing and noise reduction enables.
// R20 - Column width field plus one gives width in 16-pixel blocks.
// R21 - Walker enabled generates block positions; otherwise message positions used.
// R22 - Merge decisions: 0 deinterlace, 1 previous field, 2 next field.
// R23 - Software treats merge code 3 as undefined and zeroes reserved bits.
//
// Added by the designer: the Wishbone register port and the register offsets.
`include "ddn_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ddn_state #(
    parameter int ADR_W = 10
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Message from the execution thread.
    input wire logic msgValid,
    input wire ddn_pkg::ddn_msg_t msgIn,
    output logic msgReady,
    // Decoded answer.
    output logic respValid,
    output ddn_pkg::ddn_cfg_t respCfg,
    output ddn_pkg::ddn_err_t respErr
);

    // ==========================================================
    // Functions

    // Merges a write into a word under the byte enables.
    function automatic logic [31:0] byteMerge(input logic [31:0] oldW, input logic [31:0] newW,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = oldW;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = newW[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Turns a two-bit merge code into its decision.
    function automatic ddn_pkg::ddn_merge_t toMerge(input logic [1:0] code);
        return ddn_pkg::ddn_merge_t'(code); // R22
    endfunction

    // ==========================================================
    // Storage and state

    typedef enum logic {
        ST_IDLE,
        ST_DECODE
    } ddn_state_t;

    logic [31:0] stateMem [`DDN_ELEMS*`DDN_ELEM_DW];
    ddn_state_t state_reg;
    ddn_pkg::ddn_msg_t msg_reg;
    logic [15:0] walkX_reg;
    logic [15:0] walkY_reg;
    logic [3:0] lastErr_reg;
    logic [2:0] lastElem_reg;
    logic [7:0] msgCount_reg;
    logic busReq;
    logic [7:0] wordAdr;
    logic adrArray;
    logic walkClear;
    logic [2:0] elemSel;
    logic [5:0] base;
    logic [31:0] dwTemp;
    logic [31:0] dwBlend;
    logic [31:0] dwShift;
    logic [31:0] dwFlags;
    logic [31:0] dwWalk;
    logic [9:0] colWidth;
    ddn_pkg::ddn_cfg_t cfg_next;
    ddn_pkg::ddn_err_t err_next;

    // Bus decode; each register takes one aligned word.
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wordAdr = 8'(wb_adr_i[ADR_W-1:2]);
    assign adrArray = (wordAdr <= `DDN_ARRAY_TOP); // R1
    assign walkClear = busReq && wb_we_i && (wordAdr == `DDN_ADR_CONTROL)
                       && wb_sel_i[0] && wb_dat_i[`DDN_CTL_WALK_CLR];

    // ==========================================================
    // Wishbone slave

    // Acknowledges every access one cycle after it is seen.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    // Writes the state array under the byte enables.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `DDN_ELEMS*`DDN_ELEM_DW; i++) begin
                stateMem[i] <= `DDN_WORD_RST;
            end
        end else if (busReq && wb_we_i && adrArray) begin
            stateMem[wordAdr[5:0]] <= byteMerge(stateMem[wordAdr[5:0]], wb_dat_i, wb_sel_i);
        end
    end

    // Read data; unmapped words and the control word read as zero.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busReq && !wb_we_i) begin
            if (adrArray) begin
                wb_dat_o <= stateMem[wordAdr[5:0]];
            end else if (wordAdr == `DDN_ADR_STATUS) begin
                wb_dat_o <= {msgCount_reg, walkY_reg[7:0], 5'h00, lastElem_reg,
                             3'h0, state_reg == ST_DECODE, lastErr_reg};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Message handling

    // Takes one message, then decodes its element in the next cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            msg_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (msgValid) begin
                        msg_reg <= msgIn;
                        state_reg <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Ready while idle; drops for the decode cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msgReady <= 1'b1;
        end else begin
            msgReady <= (state_reg == ST_DECODE) || !msgValid;
        end
    end

    // Element select: the sampler index is twice the element index.
    assign elemSel = msg_reg.samplerIndex[3:1]; // R3
    assign base = {elemSel, 3'h0}; // R1
    assign dwTemp = stateMem[base | 6'(`DDN_DW_TEMPORAL)];
    assign dwBlend = stateMem[base | 6'(`DDN_DW_BLEND)];
    assign dwShift = stateMem[base | 6'(`DDN_DW_SHIFT)];
    assign dwFlags = stateMem[base | 6'(`DDN_DW_FLAGS)];
    assign dwWalk = stateMem[base | 6'(`DDN_DW_WALK)];
    assign colWidth = 10'(dwWalk[`DDN_COL_WIDTH]) + `DDN_ONE10; // R20

    // Decodes the selected element into the datapath controls.
    always_comb begin
        cfg_next = '0;
        err_next = '0;
        cfg_next.deinterlacing = dwFlags[`DDN_DI_EN];
        cfg_next.noiseReduction = dwFlags[`DDN_NR_EN];
        cfg_next.lineStep = dwFlags[`DDN_PROGRESSIVE] ? `DDN_STEP_ADJ : `DDN_STEP_ALT; // R12
        cfg_next.prevCleanValid = !dwFlags[`DDN_FIRST_FRAME]; // R13
        cfg_next.streamSel = dwFlags[`DDN_STREAM_ID]; // R14
        cfg_next.topFirst = dwFlags[`DDN_TOP_FIRST]; // R15
        cfg_next.partialWriteback = dwFlags[`DDN_DI_EN] && dwFlags[`DDN_PARTIAL]; // R16
        cfg_next.readOriginalPrev = !dwFlags[`DDN_NR_EN]; // R18
        cfg_next.divisor = 4'(dwTemp[`DDN_C2]) + `DDN_ONE4; // R6
        cfg_next.shiftDown = `DDN_SHIFT_DOWN_BASE + 3'(dwShift[`DDN_SHIFT_DOWN]); // R9
        cfg_next.shiftUp = `DDN_SHIFT_UP_BASE + 4'(dwShift[`DDN_SHIFT_UP]); // R10
        cfg_next.outShift = dwShift[`DDN_OUT_SHIFT];
        cfg_next.tdHigh = dwTemp[`DDN_TD_HI];
        cfg_next.tdLow = dwTemp[`DDN_TD_LO];
        cfg_next.blockMoving = msg_reg.movingCount > dwTemp[`DDN_MOVE_TH]; // R7
        cfg_next.columnWidth = colWidth;
        cfg_next.useWalker = dwWalk[`DDN_WALK_EN];
        // Block position from the walker or from the message.
        if (dwWalk[`DDN_WALK_EN]) begin
            cfg_next.blockX = walkX_reg; // R21
            cfg_next.blockY = walkY_reg; // R21
        end else begin
            cfg_next.blockX = msg_reg.posX; // R21
            cfg_next.blockY = msg_reg.posY; // R21
        end
        cfg_next.prevMerge = toMerge(dwWalk[`DDN_MERGE_PREV]); // R22
        cfg_next.curMerge = toMerge(dwWalk[`DDN_MERGE_CUR]); // R22
        // Motion results exist only while deinterlacing runs.
        if (dwFlags[`DDN_DI_EN]) begin
            if (dwBlend[`DDN_BLEND_SEL]) begin
                cfg_next.motionDetectThreshold = 8'(dwBlend[`DDN_BLEND_LARGE]); // R8
            end else begin
                cfg_next.motionDetectThreshold = dwBlend[`DDN_BLEND_SMALL]; // R8
            end
            cfg_next.motionMax = dwBlend[`DDN_STMM_MAX];
            cfg_next.motionMin = dwShift[`DDN_STMM_MIN];
        end else begin
            cfg_next.motionDetectThreshold = 8'h00; // R17
            cfg_next.motionMax = 8'h00; // R17
            cfg_next.motionMin = 8'h00; // R17
        end
        // Faults are flagged; the decode still completes.
        err_next.badIndex = msg_reg.samplerIndex[0] || msg_reg.samplerIndex[4]; // R3
        err_next.reservedShift = (dwShift[`DDN_SHIFT_DOWN] == `DDN_SHIFT_RSVD)
                                 || (dwShift[`DDN_SHIFT_UP] == `DDN_SHIFT_RSVD); // R9 R10
        err_next.bothOff = !dwFlags[`DDN_DI_EN] && !dwFlags[`DDN_NR_EN]; // R19
        err_next.badMerge = (dwWalk[`DDN_MERGE_PREV] == 2'h3)
                            || (dwWalk[`DDN_MERGE_CUR] == 2'h3); // R23
    end

    // Registers the answer; it stands until the next decode.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            respValid <= 1'b0;
            respCfg <= '0;
            respErr <= '0;
        end else begin
            respValid <= (state_reg == ST_DECODE);
            if (state_reg == ST_DECODE) begin
                respCfg <= cfg_next;
                respErr <= err_next;
            end
        end
    end

    // Status bookkeeping of the last decode.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lastErr_reg <= 4'h0;
            lastElem_reg <= 3'h0;
            msgCount_reg <= 8'h00;
        end else if (state_reg == ST_DECODE) begin
            lastErr_reg <= err_next;
            lastElem_reg <= elemSel;
            msgCount_reg <= msgCount_reg + 8'h01;
        end
    end

    // ==========================================================
    // Block walker

    // Steps X across the column and wraps into the next row.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            walkX_reg <= 16'h0000;
            walkY_reg <= 16'h0000;
        end else if (walkClear) begin
            walkX_reg <= 16'h0000;
            walkY_reg <= 16'h0000;
        end else if (state_reg == ST_DECODE && dwWalk[`DDN_WALK_EN]) begin
            if (walkX_reg + 16'h0001 >= 16'(colWidth)) begin // R21
                walkX_reg <= 16'h0000;
                walkY_reg <= walkY_reg + 16'h0001;
            end else begin
                walkX_reg <= walkX_reg + 16'h0001;
            end
        end
    end

endmodule // ddn_state
`default_nettype wire

// File: tb/ddn_state_asserts.sv
// Purpose: Port checks for ddn_state.
// Assumes: Bound to every ddn_state instance.
// Notes: Watches design ports only, both inputs and outputs.
`timescale 1ns/10ps
`default_nettype none
module ddn_state_asserts (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Message side.
    input wire ddn_pkg::ddn_msg_t msgIn,
    input wire logic msgValid,
    input wire logic msgReady,
    input wire logic respValid,
    input wire ddn_pkg::ddn_cfg_t respCfg,
    input wire ddn_pkg::ddn_err_t respErr
);
    // ==========
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Handshakes keep their fixed latencies.
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack late or long");
    property p_take; msgValid && msgReady |=> !msgReady && !respValid ##1 respValid; endproperty
    a_take: assert property (p_take) else $error("answer timing wrong");
    // Decoded fields follow their causes.
    property p_idx; respValid |-> respErr.badIndex ==
        ($past(msgIn.samplerIndex[0], 2) || $past(msgIn.samplerIndex[4], 2)); endproperty
    a_idx: assert property (p_idx) else $error("index fault wrong");
    property p_div; respValid |-> respCfg.divisor != 4'h0 && respCfg.divisor <= 4'h8; endproperty
    a_div: assert property (p_div) else $error("divisor out of range");
    property p_down; respValid && !respErr.reservedShift |->
        respCfg.shiftDown inside {3'h4, 3'h5, 3'h6}; endproperty
    a_down: assert property (p_down) else $error("down shift wrong");
    property p_up; respValid && !respErr.reservedShift |->
        respCfg.shiftUp inside {4'h6, 4'h7, 4'h8}; endproperty
    a_up: assert property (p_up) else $error("up shift wrong");
    property p_part; respValid && respCfg.partialWriteback |-> respCfg.deinterlacing; endproperty
    a_part: assert property (p_part) else $error("partial without deinterlace");
    property p_dioff; respValid && !respCfg.deinterlacing |-> {respCfg.motionDetectThreshold,
        respCfg.motionMax, respCfg.motionMin} == 24'h0; endproperty
    a_dioff: assert property (p_dioff) else $error("motion values not zero");
    property p_nr; respValid |-> respCfg.readOriginalPrev != respCfg.noiseReduction; endproperty
    a_nr: assert property (p_nr) else $error("previous frame source wrong");
    property p_walk; respValid && !respCfg.useWalker |->
        respCfg.blockX == $past(msgIn.posX, 2); endproperty
    a_walk: assert property (p_walk) else $error("block position wrong");
endmodule // ddn_state_asserts
bind ddn_state ddn_state_asserts ddn_state_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .msgIn(msgIn), .msgValid(msgValid), .msgReady(msgReady),
    .respValid(respValid), .respCfg(respCfg), .respErr(respErr)
);
`default_nettype wire

// File: tb/ddn_thread.sv
// Purpose: Execution thread that issues decode messages.
// Assumes: The bench pulses sendReq with the message in sendMsg.
// Notes: Released lines carry the inverse of the last message.
`timescale 1ns/10ps
`default_nettype none
module ddn_thread (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench command.
    input wire logic sendReq,
    input wire ddn_pkg::ddn_msg_t sendMsg,
    // Message port.
    input wire logic msgReady,
    output logic msgValid,
    output ddn_pkg::ddn_msg_t msgIn
);
    // Holds a message until taken, so a late take is never missed.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msgValid <= 1'h0;
            msgIn <= 42'h0;
        end else if (msgValid && msgReady) begin
            msgValid <= 1'h0;
            msgIn <= ~msgIn;
        end else if (sendReq && !msgValid) begin
            msgValid <= 1'h1;
            msgIn <= sendMsg;
        end
    end
endmodule // ddn_thread
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for ddn_state.
// Assumes: ddn_thread issues messages; the checker is bound.
// Notes: Table rows first, then walker, fault, bus and reset cases.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // One row: element words and the decode they should give.
    typedef struct packed {
        logic [2:0] elem;
        logic [31:0] d1, d3, d4, d6, d7;
        logic [4:0] mov;
        logic [3:0] div, su;
        logic [2:0] sd;
        logic [9:0] cw;
        logic mv;
        logic [7:0] mdt;
    } ddn_row_t;
    logic clk_sys, wbAck, msgValid, msgReady, respValid;
    logic rst_n = 1'h0, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, sendReq = 1'h0;
    logic [9:0] wbAdr = 10'h000;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    ddn_pkg::ddn_msg_t sendMsg = 42'h0, msgIn;
    ddn_pkg::ddn_cfg_t respCfg;
    ddn_pkg::ddn_err_t respErr;
    int err_count = 0;
    int cmp_count = 0;
    ddn_row_t rows [3] = '{
        '{3'h0, 32'h1008_0400, 32'hD522_0040, 32'h2005_0000, 32'h0F, 32'h0, 5'h05,
          4'h1, 4'h6, 3'h4, 10'h001, 1'h1, 8'h55},
        '{3'h3, 32'h2010_F000, 32'h5522_0040, 32'h2055_0000, 32'h32, 32'hFF81_0200, 5'h10,
          4'h8, 4'h7, 3'h5, 10'h200, 1'h0, 8'h22},
        '{3'h7, 32'h3020_6000, 32'hD522_0040, 32'h20A5_0000, 32'h41, 32'h0282_0100, 5'h00,
          4'h4, 4'h8, 3'h6, 10'h006, 1'h0, 8'h00}};
    ddn_state #(.ADR_W(10)) ddn_state_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .msgValid(msgValid), .msgIn(msgIn), .msgReady(msgReady),
        .respValid(respValid), .respCfg(respCfg), .respErr(respErr));
    ddn_thread ddn_thread_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sendReq(sendReq),
        .sendMsg(sendMsg), .msgReady(msgReady), .msgValid(msgValid), .msgIn(msgIn));
    // Makes the 40 MHz clock.
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Prints the verdict and ends the run.
    task automatic give_verdict;
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Compares one value and reports a difference.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Waits one cycle and gives up when a wait runs too long.
    // Samples on the falling edge, where registered outputs have settled.
    task automatic tick(inout int n);
        n++;
        if (n > 30) begin
            err_count++;
            give_verdict();
        end
        @(negedge clk_sys);
    endtask
    // One classic Wishbone cycle, held until ack is sampled.
    task automatic bus(input logic we, input logic [9:0] a, input logic [3:0] s,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'h3, we, a, s, d};
        @(negedge clk_sys);
        while (wbAck !== 1'h1) tick(n);
        q = wbDatO;
        @(posedge clk_sys);
        {wbCyc, wbStb} <= 2'h0;
    endtask
    // Issues one message and waits for its answer.
    task automatic msg(input logic [4:0] idx, input logic [4:0] mov);
        int n;
        n = 0;
        @(posedge clk_sys);
        sendMsg <= {idx, mov, 16'h1230 + {11'h0, idx}, 16'h0F00};
        sendReq <= 1'h1;
        @(posedge clk_sys);
        sendReq <= 1'h0;
        @(negedge clk_sys);
        while (respValid !== 1'h1) tick(n);
    endtask
    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        ddn_row_t r;
        logic [9:0] b;
        logic [31:0] q, e;
        logic [15:0] x0, x1;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'h1;
        bus(1'h0, 10'h0D4, 4'hF, 32'h0, q);
        chk("reset word", q, 32'h0);
        foreach (rows[i]) begin
            r = rows[i];
            b = {2'h0, r.elem, 5'h00};
            bus(1'h1, b, 4'hF, 32'h10F0_0820, q);
            bus(1'h1, b + 10'h004, 4'hF, r.d1, q);
            bus(1'h1, b + 10'h00C, 4'hF, r.d3, q);
            bus(1'h1, b + 10'h010, 4'hF, r.d4, q);
            bus(1'h1, b + 10'h018, 4'hF, r.d6, q);
            bus(1'h1, b + 10'h01C, 4'hF, r.d7, q);
            bus(1'h0, b + 10'h018, 4'hF, 32'h0, q);
            chk("flags word", q, r.d6);
            msg({1'h0, r.elem, 1'h0}, r.mov);
            q = {2'h0, respCfg.divisor, respCfg.shiftUp, respCfg.shiftDown, respCfg.columnWidth,
                respCfg.blockMoving, respCfg.motionDetectThreshold};
            chk("decode", q, {2'h0, r.div, r.su, r.sd, r.cw, r.mv, r.mdt});
            q = {19'h0, respCfg.prevMerge, respCfg.curMerge, respCfg.lineStep,
                respCfg.prevCleanValid, respCfg.streamSel, respCfg.topFirst,
                respCfg.partialWriteback, respCfg.deinterlacing, respCfg.noiseReduction,
                respCfg.readOriginalPrev};
            e = {19'h0, r.d7[17:16], r.d7[9:8], r.d6[6] ? 2'h1 : 2'h2, ~r.d6[5], r.d6[4:3],
                r.d6[2] & r.d6[1], r.d6[1:0], ~r.d6[0]};
            chk("flags", q, e);
        end
        bus(1'h1, 10'h058, 4'hF, 32'h3, q);
        bus(1'h1, 10'h05C, 4'hF, 32'h0084_0000, q);
        bus(1'h1, 10'h104, 4'hF, 32'h1, q);
        msg(5'h04, 5'h00);
        x0 = respCfg.blockX;
        msg(5'h04, 5'h00);
        x1 = respCfg.blockX;
        msg(5'h04, 5'h00);
        chk("walker wrap", {16'h0, respCfg.blockX}, {16'h0, x0});
        chk("walker step", {31'h0, x1 === x0}, 32'h0);
        bus(1'h1, 10'h030, 4'hF, 32'h20C5_0000, q);
        bus(1'h1, 10'h03C, 4'hF, 32'h0003_0000, q);
        msg(5'h02, 5'h00);
        chk("fault flags", {28'h0, respErr}, 32'h7);
        msg(5'h03, 5'h00);
        chk("odd index", {28'h0, respErr}, 32'hF);
        msg(5'h12, 5'h00);
        chk("high index", {28'h0, respErr}, 32'hF);
        bus(1'h0, 10'h100, 4'hF, 32'h0, q);
        chk("status", q, 32'h0901_010F);
        bus(1'h0, 10'h104, 4'hF, 32'h0, q);
        chk("control reads zero", q, 32'h0);
        bus(1'h1, 10'h080, 4'h2, 32'hFFFF_FFFF, q);
        bus(1'h0, 10'h080, 4'hF, 32'h0, q);
        chk("lane write", q, 32'h0000_FF00);
        bus(1'h0, 10'h108, 4'hF, 32'h0, q);
        chk("unmapped", q, 32'h0);
        @(posedge clk_sys);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk_sys);
        chk("ready in reset", {31'h0, msgReady}, 32'h1);
        rst_n <= 1'h1;
        bus(1'h0, 10'h004, 4'hF, 32'h0, q);
        chk("word after reset", q, 32'h0);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
